// file: dv/radio_debug_sync_length_regs_tb.sv
`timescale 1ns/10ps
`default_nettype none
module radio_debug_sync_length_regs_tb;
    import radio_regs_pkg::*;
    logic clk, rst, reg_wr, reg_rd, rx_active, freq_sample_valid, variable_length_mode;
    logic rx_length_valid, length_accept, length_checked, drive, inv, ds;
    logic [2:0] pins;
    logic [15:0] reg_addr, sync_word;
    logic [7:0] reg_wdata, reg_rdata, freq_sample, rx_length, packet_length, hi, lo, est, len;
    logic [5:0] sel;
    logic [SIG_W-1:0] radio_signals;
    logic [15:0] paddr [3] = '{PIN_A_ADDR, PIN_B_ADDR, PIN_C_ADDR};
    logic rd_pend = 1'b0;
    logic [7:0] exp_q[$];
    logic len_q[$];
    int fail_count, n_checks, sum, p;

    radio_debug_sync_length_regs u_dut (
        .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .radio_signals(radio_signals), .rx_active(rx_active),
        .freq_sample_valid(freq_sample_valid), .freq_sample(freq_sample),
        .variable_length_mode(variable_length_mode), .rx_length_valid(rx_length_valid),
        .rx_length(rx_length), .sync_word(sync_word), .packet_length(packet_length),
        .length_accept(length_accept), .length_checked(length_checked),
        .port_one_bit_seven(pins[2]), .port_one_bit_six(pins[1]),
        .port_one_bit_five(pins[0]), .debug_drive_strength(drive)
    );

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ========================================
    // Checking
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    always @(posedge clk) rd_pend <= reg_rd;

    // Read data stands only in the cycle after the strobe
    always @(negedge clk)
    begin
        if (rd_pend)
            chk({8'h00, reg_rdata}, {8'h00, exp_q.pop_front()});
        else
            chk({8'h00, reg_rdata}, 16'h0000);
        if (length_checked)
            chk({15'h0, length_accept}, {15'h0, len_q.pop_front()});
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        fail_count++;
        tally_and_finish();
    end

    // ========================================
    // Bus tasks
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask

    task automatic feed(input int n, output int total);
        logic [7:0] v;
        total = 0;
        for (int k = 0; k < n; k++)
        begin
            v = 8'($urandom);
            freq_sample <= v;
            freq_sample_valid <= 1'b1;
            total += $signed(v);
            @(posedge clk);
        end
        freq_sample_valid <= 1'b0;
    endtask

    // ========================================
    // Main sequence
    initial
    begin
        rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 16'h0000;
        reg_wdata = 8'h00;
        rx_active = 1'b0;
        freq_sample_valid = 1'b0;
        freq_sample = 8'h00;
        variable_length_mode = 1'b0;
        rx_length_valid = 1'b0;
        rx_length = 8'h00;
        radio_signals = '0;
        fail_count = 0;
        n_checks = 0;
        void'($urandom(32'hd92b));
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rd(SYNC_HIGH_ADDR, 8'hd3);
        rd(SYNC_LOW_ADDR, 8'h91);
        rd(PKT_LEN_ADDR, 8'hff);
        for (int i = 0; i < 3; i++)
            rd(paddr[i], 8'h00);
        rd(16'hdf03, 8'h00);
        @(negedge clk);
        chk(sync_word, 16'hd391);
        chk({8'h00, packet_length}, 16'h00ff);
        chk({15'h0, drive}, 16'h0000);
        $display("test reset_values done");

        hi = 8'($urandom);
        lo = 8'($urandom);
        wr(SYNC_HIGH_ADDR, hi);
        wr(SYNC_LOW_ADDR, lo);
        wr(PKT_LEN_ADDR, 8'h40);
        wr(16'hdf03, 8'h5a);
        rd(SYNC_HIGH_ADDR, hi);
        rd(SYNC_LOW_ADDR, lo);
        rd(PKT_LEN_ADDR, 8'h40);
        rd(16'hdf03, 8'h00);
        @(negedge clk);
        chk(sync_word, {hi, lo});
        chk({8'h00, packet_length}, 16'h0040);
        $display("test sync_length done");

        wr(PIN_C_ADDR, 8'hff);
        wr(PIN_B_ADDR, 8'hc0);
        wr(PIN_A_ADDR, 8'hff);
        rd(PIN_C_ADDR, 8'h7f);
        rd(PIN_B_ADDR, 8'hc0);
        rd(PIN_A_ADDR, 8'h7f);
        @(negedge clk);
        chk({15'h0, drive}, 16'h0001);
        $display("test unused_bits done");

        for (int i = 0; i < 15; i++)
        begin
            p = i % 3;
            sel = 6'($urandom);
            inv = 1'($urandom);
            ds = 1'($urandom);
            @(posedge clk);
            radio_signals <= {$urandom, $urandom};
            wr(paddr[p], {ds, inv, sel});
            repeat (2) @(posedge clk);
            radio_signals <= ~radio_signals;
            @(posedge clk);
            @(negedge clk);
            chk({15'h0, pins[p]}, {15'h0, radio_signals[sel] ^ inv});
            if (p == 1)
                chk({15'h0, drive}, {15'h0, ds});
        end
        $display("test debug_pins done");

        @(posedge clk);
        rx_active <= 1'b1;
        repeat (2) @(posedge clk);
        feed(8, sum);
        est = 8'(sum >>> 3);
        repeat (2) @(posedge clk);
        rd(FREQ_EST_ADDR, est);
        wr(FREQ_EST_ADDR, ~est);
        feed(3, sum);
        rx_active <= 1'b0;
        rd(FREQ_EST_ADDR, est);
        $display("test offset_estimate done");

        for (int m = 0; m < 2; m++)
            for (int d = 0; d < 3; d++)
            begin
                @(posedge clk);
                len = 8'h3f + 8'(d);
                variable_length_mode <= 1'(m);
                rx_length <= len;
                rx_length_valid <= 1'b1;
                len_q.push_back(m == 1 ? len <= 8'h40 : len == 8'h40);
            end
        @(posedge clk);
        rx_length_valid <= 1'b0;
        repeat (3) @(posedge clk);
        chk(16'(len_q.size()), 16'h0000);
        chk(16'(exp_q.size()), 16'h0000);
        $display("test length_check done");
        tally_and_finish();
    end
endmodule
`default_nettype wire

// file: src/debug_pin_mux.sv
`timescale 1ns/10ps
`default_nettype none
module debug_pin_mux
(
    input wire logic clk, // System clock
    input wire logic rst, // Async reset, high
    input wire radio_regs_pkg::pin_cfg_s cfg, // Select and invert
    input wire logic [radio_regs_pkg::SIG_W-1:0] radio_signals, // Internal signals
    output logic pin_out // Debug pin level
);
    import radio_regs_pkg::*;

    logic pin_reg;
    logic pin_next;

    // ========================================
    // Selection and polarity
    always_comb
    begin
        pin_next = radio_signals[cfg.select] ^ cfg.invert;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pin_reg <= 1'b0;
        end
        else
        begin
            pin_reg <= pin_next;
        end
    end

    assign pin_out = pin_reg;

    // ========================================
    // Checks
    pin_route_a: assert property (@(posedge clk) disable iff (rst)
        ##1 pin_out == ($past(radio_signals[cfg.select]) ^ $past(cfg.invert)))
        else $error("debug pin does not follow selected signal");
    pin_invert_a: assert property (@(posedge clk) disable iff (rst)
        (cfg.invert && $stable(cfg) && $stable(radio_signals)) ##1
        ($stable(cfg) && $stable(radio_signals)) |-> pin_out == !radio_signals[cfg.select])
        else $error("inverted pin is not active low");

endmodule
`default_nettype wire

// file: src/freq_offset_meter.sv
`timescale 1ns/10ps
`default_nettype none
module freq_offset_meter
(
    input wire logic clk, // System clock
    input wire logic rst, // Async reset, high
    input wire logic rx_active, // Receiver running
    input wire logic sample_valid, // Offset sample strobe
    input wire logic [7:0] sample, // Signed offset sample
    output logic [7:0] estimate // Averaged offset, signed
);
    import radio_regs_pkg::*;

    meas_state_e state_reg, state_next;
    logic [SUM_W-1:0] sum_reg, sum_next, sum_total;
    logic [EST_LOG2-1:0] count_reg, count_next;
    logic [7:0] est_reg, est_next;

    // ========================================
    // Average of eight samples while receiving
    always_comb
    begin
        sum_total = sum_reg + {{(SUM_W-8){sample[7]}}, sample};
        state_next = state_reg;
        sum_next = sum_reg;
        count_next = count_reg;
        est_next = est_reg;
        case (state_reg)
            MEAS_IDLE:
            begin
                sum_next = '0;
                count_next = '0;
                if (rx_active)
                begin
                    state_next = MEAS_ACCUM;
                end
            end
            MEAS_ACCUM:
            begin
                if (!rx_active)
                begin
                    state_next = MEAS_IDLE;
                end
                else if (sample_valid)
                begin
                    sum_next = sum_total;
                    count_next = count_reg + 3'h1;
                    if (count_reg == EST_LAST)
                    begin
                        est_next = sum_total[SUM_W-1:EST_LOG2];
                        sum_next = '0;
                    end
                end
            end
            default:
            begin
                state_next = MEAS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg <= MEAS_IDLE;
            sum_reg <= '0;
            count_reg <= '0;
            est_reg <= FREQ_EST_RST;
        end
        else
        begin
            state_reg <= state_next;
            sum_reg <= sum_next;
            count_reg <= count_next;
            est_reg <= est_next;
        end
    end

    assign estimate = est_reg;

    // ========================================
    // Checks
    sequence last_sample_s;
        state_reg == MEAS_ACCUM && rx_active && sample_valid && count_reg == EST_LAST;
    endsequence

    est_update_a: assert property (@(posedge clk) disable iff (rst)
        last_sample_s |=> estimate == $past(sum_total[SUM_W-1:EST_LOG2]))
        else $error("offset estimate not latched after eighth sample");

endmodule
`default_nettype wire

// file: src/radio_debug_sync_length_regs.sv
`timescale 1ns/10ps
`default_nettype none
module radio_debug_sync_length_regs
(
    input wire logic clk, // System clock, 200 MHz
    input wire logic rst, // Async reset, high
    input wire logic [15:0] reg_addr, // Register address
    input wire logic [7:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [7:0] reg_rdata, // Read data, cycle after strobe
    input wire logic [radio_regs_pkg::SIG_W-1:0] radio_signals, // Debug sources
    input wire logic rx_active, // Receiver running
    input wire logic freq_sample_valid, // Offset sample strobe
    input wire logic [7:0] freq_sample, // Signed offset sample
    input wire logic variable_length_mode, // 1 variable, 0 fixed
    input wire logic rx_length_valid, // Received length strobe
    input wire logic [7:0] rx_length, // Received length byte
    output logic [15:0] sync_word, // Sync word to the modem
    output logic [7:0] packet_length, // Length setting
    output logic length_accept, // Last length was acceptable
    output logic length_checked, // Check result pulse
    output logic port_one_bit_seven, // Debug pin c
    output logic port_one_bit_six, // Debug pin b
    output logic port_one_bit_five, // Debug pin a
    output logic debug_drive_strength // 1 maximum drive
);
    import radio_regs_pkg::*;

    // ========================================
    // State
    logic [7:0] sync_high_reg, sync_high_next;
    logic [7:0] sync_low_reg, sync_low_next;
    logic [7:0] pkt_len_reg, pkt_len_next;
    pin_cfg_s pin_cfg_reg [NUM_PINS];
    pin_cfg_s pin_cfg_next [NUM_PINS];
    logic drive_reg, drive_next;
    logic [7:0] rdata_reg, rdata_next;
    logic len_ok_reg, len_ok_next;
    logic len_chk_reg, len_chk_next;
    logic [7:0] freq_estimate;
    logic [NUM_PINS-1:0] pin_bus;

    // ========================================
    // Register writes
    always_comb
    begin
        sync_high_next = sync_high_reg;
        sync_low_next = sync_low_reg;
        pkt_len_next = pkt_len_reg;
        drive_next = drive_reg;
        for (int i = 0; i < NUM_PINS; i++)
        begin
            pin_cfg_next[i] = pin_cfg_reg[i];
        end
        if (reg_wr)
        begin
            case (reg_addr)
                SYNC_HIGH_ADDR:
                begin
                    sync_high_next = reg_wdata;
                end
                SYNC_LOW_ADDR:
                begin
                    sync_low_next = reg_wdata;
                end
                PKT_LEN_ADDR:
                begin
                    pkt_len_next = reg_wdata;
                end
                PIN_C_ADDR:
                begin
                    pin_cfg_next[PIN_C] = reg_wdata[INV_BIT:0];
                end
                PIN_B_ADDR:
                begin
                    pin_cfg_next[PIN_B] = reg_wdata[INV_BIT:0];
                    drive_next = reg_wdata[DS_BIT];
                end
                PIN_A_ADDR:
                begin
                    pin_cfg_next[PIN_A] = reg_wdata[INV_BIT:0];
                end
                default:
                begin
                    drive_next = drive_reg;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sync_high_reg <= SYNC_HIGH_RST;
            sync_low_reg <= SYNC_LOW_RST;
            pkt_len_reg <= PKT_LEN_RST;
            drive_reg <= PIN_CFG_RST[DS_BIT];
            for (int i = 0; i < NUM_PINS; i++)
            begin
                pin_cfg_reg[i] <= PIN_CFG_RST[INV_BIT:0];
            end
        end
        else
        begin
            sync_high_reg <= sync_high_next;
            sync_low_reg <= sync_low_next;
            pkt_len_reg <= pkt_len_next;
            drive_reg <= drive_next;
            for (int i = 0; i < NUM_PINS; i++)
            begin
                pin_cfg_reg[i] <= pin_cfg_next[i];
            end
        end
    end

    // ========================================
    // Register reads
    always_comb
    begin
        rdata_next = UNMAPPED_READ;
        if (reg_rd)
        begin
            case (reg_addr)
                SYNC_HIGH_ADDR:
                begin
                    rdata_next = sync_high_reg;
                end
                SYNC_LOW_ADDR:
                begin
                    rdata_next = sync_low_reg;
                end
                PKT_LEN_ADDR:
                begin
                    rdata_next = pkt_len_reg;
                end
                PIN_C_ADDR:
                begin
                    rdata_next = {1'b0, pin_cfg_reg[PIN_C]};
                end
                PIN_B_ADDR:
                begin
                    rdata_next = {drive_reg, pin_cfg_reg[PIN_B]};
                end
                PIN_A_ADDR:
                begin
                    rdata_next = {1'b0, pin_cfg_reg[PIN_A]};
                end
                FREQ_EST_ADDR:
                begin
                    rdata_next = freq_estimate;
                end
                default:
                begin
                    rdata_next = UNMAPPED_READ;
                end
            endcase
        end
    end

    // ========================================
    // Packet length check
    always_comb
    begin
        len_chk_next = rx_length_valid;
        len_ok_next = len_ok_reg;
        if (rx_length_valid)
        begin
            if (variable_length_mode)
            begin
                len_ok_next = rx_length <= pkt_len_reg;
            end
            else
            begin
                len_ok_next = rx_length == pkt_len_reg;
            end
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rdata_reg <= UNMAPPED_READ;
            len_ok_reg <= 1'b0;
            len_chk_reg <= 1'b0;
        end
        else
        begin
            rdata_reg <= rdata_next;
            len_ok_reg <= len_ok_next;
            len_chk_reg <= len_chk_next;
        end
    end

    // ========================================
    // Debug pins and offset meter
    for (genvar p = 0; p < NUM_PINS; p++)
    begin : g_pin
        debug_pin_mux u_mux
        (
            .clk(clk),
            .rst(rst),
            .cfg(pin_cfg_reg[p]),
            .radio_signals(radio_signals),
            .pin_out(pin_bus[p])
        );
    end

    freq_offset_meter u_meter
    (
        .clk(clk),
        .rst(rst),
        .rx_active(rx_active),
        .sample_valid(freq_sample_valid),
        .sample(freq_sample),
        .estimate(freq_estimate)
    );

    // ========================================
    // Outputs
    assign reg_rdata = rdata_reg;
    assign sync_word = {sync_high_reg, sync_low_reg};
    assign packet_length = pkt_len_reg;
    assign length_accept = len_ok_reg;
    assign length_checked = len_chk_reg;
    assign port_one_bit_seven = pin_bus[PIN_C];
    assign port_one_bit_six = pin_bus[PIN_B];
    assign port_one_bit_five = pin_bus[PIN_A];
    assign debug_drive_strength = drive_reg;

    // ========================================
    // Checks
    sequence write_s(logic [15:0] a);
        reg_wr && reg_addr == a;
    endsequence

    sequence read_s(logic [15:0] a);
        reg_rd && reg_addr == a;
    endsequence

    sync_reset_a: assert property (@(posedge clk)
        $fell(rst) |-> sync_word == {SYNC_HIGH_RST, SYNC_LOW_RST})
        else $error("sync word reset value wrong");

    sync_write_a: assert property (@(posedge clk) disable iff (rst)
        write_s(SYNC_HIGH_ADDR) ##1 read_s(SYNC_HIGH_ADDR)
        |=> reg_rdata == $past(sync_word[15:8]) && sync_word[15:8] == $past(reg_wdata, 2))
        else $error("sync high byte write not read back");

    outer_bit7_a: assert property (@(posedge clk) disable iff (rst)
        (read_s(PIN_C_ADDR) or read_s(PIN_A_ADDR)) |=> reg_rdata[DS_BIT] == 1'b0)
        else $error("unused bit 7 reads as one");

    drive_write_a: assert property (@(posedge clk) disable iff (rst)
        write_s(PIN_B_ADDR) |=> debug_drive_strength == $past(reg_wdata[DS_BIT])
        ##1 !$past(reg_wr) || debug_drive_strength == $past(debug_drive_strength))
        else $error("drive strength bit not taken from pin b register");

    length_mode_a: assert property (@(posedge clk) disable iff (rst)
        rx_length_valid |=> length_checked && length_accept == ($past(variable_length_mode)
        ? ($past(rx_length) <= $past(packet_length))
        : ($past(rx_length) == $past(packet_length))))
        else $error("length check ignores fixed or variable mode");

    est_read_a: assert property (@(posedge clk) disable iff (rst)
        read_s(FREQ_EST_ADDR) |=> reg_rdata == $past(freq_estimate))
        else $error("offset estimate not readable");

endmodule
`default_nettype wire

// file: src/radio_regs_pkg.sv
// Function
// - Measure transmitter frequency offset and expose it in a readable status register.
// - Bit 6 of each debug pin register inverts its pin: 1 low, 0 high.
// - Bits 5:0 of each debug pin register select the routed signal, reset zero.
// - Bit 7 of the middle pin register sets drive strength: 0 minimum, 1 maximum.
// - Sync word is high byte (reset 0xd3) joined with low byte (reset 0x91).
// - Length register, reset 0xff, is exact length fixed, maximum length variable.
package radio_regs_pkg;

    // ========================================
    // Register map
    localparam logic [15:0] SYNC_HIGH_ADDR = 16'hdf00;
    localparam logic [15:0] SYNC_LOW_ADDR = 16'hdf01;
    localparam logic [15:0] PKT_LEN_ADDR = 16'hdf02;
    localparam logic [15:0] PIN_C_ADDR = 16'hdf2f;
    localparam logic [15:0] PIN_B_ADDR = 16'hdf30;
    localparam logic [15:0] PIN_A_ADDR = 16'hdf31;
    localparam logic [15:0] FREQ_EST_ADDR = 16'hdf32;

    // ========================================
    // Reset values
    localparam logic [7:0] SYNC_HIGH_RST = 8'hd3;
    localparam logic [7:0] SYNC_LOW_RST = 8'h91;
    localparam logic [7:0] PKT_LEN_RST = 8'hff;
    localparam logic [7:0] PIN_CFG_RST = 8'h00;
    localparam logic [7:0] FREQ_EST_RST = 8'h00;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // ========================================
    // Field layout and sizes
    localparam int DS_BIT = 7;
    localparam int INV_BIT = 6;
    localparam int SEL_W = 6;
    localparam int NUM_PINS = 3;
    localparam int PIN_A = 0;
    localparam int PIN_B = 1;
    localparam int PIN_C = 2;
    localparam int SIG_W = 64;
    localparam int EST_LOG2 = 3;
    localparam int SUM_W = 11;
    localparam logic [EST_LOG2-1:0] EST_LAST = 3'h7;

    typedef struct packed {
        logic invert;
        logic [SEL_W-1:0] select;
    } pin_cfg_s;

    typedef enum logic [1:0] {
        MEAS_IDLE = 2'b01,
        MEAS_ACCUM = 2'b10
    } meas_state_e;

endpackage
